// ==== hdl/smcm_pkg.sv ====
package smcm_pkg;
  // Register map: four words per chip select
  localparam logic [7:0] SMCM_CS_STRIDE = 8'h10;
  localparam logic [3:0] SMCM_OFF_SETUP = 4'h0;
  localparam logic [3:0] SMCM_OFF_PULSE = 4'h4;
  localparam logic [3:0] SMCM_OFF_CYCLE = 4'h8;
  localparam logic [3:0] SMCM_OFF_MODE = 4'hC;
  localparam logic [7:0] SMCM_OFF_STATUS = 8'h80;
  localparam logic [31:0] SMCM_RST_SETUP = 32'h01010101;
  localparam logic [31:0] SMCM_RST_PULSE = 32'h01010101;
  localparam logic [31:0] SMCM_RST_CYCLE = 32'h00030003;
  localparam logic [31:0] SMCM_RST_MODE = 32'h10001000;
  // Field positions in chip_select_mode
  localparam int SMCM_F_RDMODE = 0;
  localparam int SMCM_F_WRMODE = 1;
  localparam int SMCM_F_WAIT = 4;
  localparam int SMCM_F_BAT = 8;
  localparam int SMCM_F_DBW = 12;
  localparam int SMCM_F_TDF = 16;
  localparam int SMCM_F_TDFOPT = 20;
  localparam int SMCM_F_PAGE_MODE_EN = 24;
  localparam int SMCM_F_PS = 28;
  localparam logic [31:0] SMCM_MODE_MASK = 32'h311F3133;
  localparam logic [31:0] SMCM_SETUP_MASK = 32'h3F3F3F3F;
  localparam logic [31:0] SMCM_PULSE_MASK = 32'h7F7F7F7F;
  localparam logic [31:0] SMCM_CYCLE_MASK = 32'h01FF01FF;
  localparam logic [1:0] SMCM_WAIT_OFF = 2'h0;
  localparam logic [1:0] SMCM_WAIT_FROZEN = 2'h2;
  localparam logic [1:0] SMCM_WAIT_READY = 2'h3;
  localparam logic [1:0] SMCM_DBW_8 = 2'h0;
  localparam logic [9:0] SMCM_MUL_SETUP = 10'h080;
  localparam logic [9:0] SMCM_MUL_LONG = 10'h100;

  typedef enum logic [2:0] {
    SMCM_IDLE = 3'b000,
    SMCM_SETUP = 3'b001,
    SMCM_PULSE = 3'b010,
    SMCM_HOLD = 3'b011,
    SMCM_FLOAT = 3'b100
  } smcm_state_t;

  // Per-access timing chosen for the addressed select
  typedef struct packed {
    logic [9:0] setup;
    logic [9:0] pulse;
    logic [9:0] cycle;
  } smcm_timing_t;

  // External strobe bundle, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic we_n;
    logic [3:0] bwr_n;
    logic [3:0] bls_n;
  } smcm_strobes_t;
endpackage

// ==== hdl/smcm_wait_sync.sv ====
`timescale 1ns/1ns
module smcm_wait_sync import smcm_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic sync_q;

  // Two-stage synchroniser; the first stage feeds nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // smcm_wait_sync

// ==== hdl/smcm_len_decode.sv ====
`timescale 1ns/1ns
module smcm_len_decode import smcm_pkg::*; (
  input wire logic [5:0] setup_i,
  input wire logic [6:0] pulse_i,
  input wire logic [8:0] cycle_i,
  output smcm_timing_t timing_o
);
  // Setup: bit5 weighs 128, pulse: bit6 weighs 256, cycle: [8:7] times 256
  assign timing_o.setup = (setup_i[5] ? SMCM_MUL_SETUP : 10'h000) + {5'h00, setup_i[4:0]};
  assign timing_o.pulse = (pulse_i[6] ? SMCM_MUL_LONG : 10'h000) + {4'h0, pulse_i[5:0]};
  assign timing_o.cycle = 10'(cycle_i[8:7] * SMCM_MUL_LONG) + {3'h0, cycle_i[6:0]};
endmodule // smcm_len_decode

// ==== hdl/smcm_ctrl.sv ====
`timescale 1ns/1ns
module smcm_ctrl import smcm_pkg::*; #(
  parameter int NUM_CS = 8,
  parameter int ADDR_W = 26
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone register slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Access request port
  input wire logic req_i,
  input wire logic req_we_i,
  input wire logic [2:0] req_cs_i,
  input wire logic [ADDR_W-1:0] req_adr_i,
  input wire logic [3:0] req_be_i,
  output logic req_done_o,
  // External memory pins
  input wire logic wait_input_i,
  output logic [NUM_CS-1:0] cs_n_o,
  output smcm_strobes_t strobes_o,
  output logic [ADDR_W-1:0] mem_adr_o
);
  // One register set per select; reserved bits always read back as zero
  logic [31:0] setup_q [NUM_CS];
  logic [31:0] pulse_q [NUM_CS];
  logic [31:0] cycle_q [NUM_CS];
  logic [31:0] mode_q [NUM_CS];
  smcm_state_t state_q;
  logic [9:0] cnt_q;
  logic [9:0] tot_q;
  logic [4:0] flt_q;
  logic [2:0] fcs_q;
  logic [2:0] cs_q;
  logic wr_q;
  logic page_hit_q;
  logic page_valid_q;
  logic [ADDR_W-1:0] page_adr_q;
  logic [3:0] be_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic wait_sync;
  smcm_timing_t rd_cs_t;
  smcm_timing_t rd_rd_t;
  smcm_timing_t wr_cs_t;
  smcm_timing_t wr_we_t;

  // Register decode
  wire [2:0] reg_cs = adr_i[6:4];
  wire [3:0] reg_off = adr_i[3:0];
  wire reg_in_cs = (adr_i[7] == 1'b0) && (adr_i[1:0] == 2'b00);
  wire reg_status = (adr_i == SMCM_OFF_STATUS);
  wire wb_req = cyc_i && stb_i && !ack_q;
  wire wb_wr = wb_req && we_i && reg_in_cs;
  wire [31:0] byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  // Mode of the select being served
  wire [31:0] mode_cur = mode_q[cs_q];
  wire rd_ctrl_strobe = mode_cur[SMCM_F_RDMODE];
  wire wr_ctrl_strobe = mode_cur[SMCM_F_WRMODE];
  wire [1:0] wait_mode = mode_cur[SMCM_F_WAIT +: 2];
  wire byte_write_type = mode_cur[SMCM_F_BAT];
  wire [1:0] bus_width_sel = mode_cur[SMCM_F_DBW +: 2];
  wire [3:0] float_cycles = mode_cur[SMCM_F_TDF +: 4];
  wire float_optimise = mode_cur[SMCM_F_TDFOPT];
  wire page_mode_en = mode_cur[SMCM_F_PAGE_MODE_EN];
  wire [1:0] page_size_sel = mode_cur[SMCM_F_PS +: 2];

  smcm_wait_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(wait_input_i),
    .sync_o(wait_sync)
  );

  // Decode all four strobe timings for the active select
  smcm_len_decode u_rdcs (
    .setup_i(setup_q[cs_q][29:24]),
    .pulse_i(pulse_q[cs_q][30:24]),
    .cycle_i(cycle_q[cs_q][24:16]),
    .timing_o(rd_cs_t)
  );
  // Read strobe timing; its pulse also times later page hits
  smcm_len_decode u_rdrd (
    .setup_i(setup_q[cs_q][21:16]),
    .pulse_i(pulse_q[cs_q][22:16]),
    .cycle_i(cycle_q[cs_q][24:16]),
    .timing_o(rd_rd_t)
  );
  // Select timing for writes
  smcm_len_decode u_wrcs (
    .setup_i(setup_q[cs_q][13:8]),
    .pulse_i(pulse_q[cs_q][14:8]),
    .cycle_i(cycle_q[cs_q][8:0]),
    .timing_o(wr_cs_t)
  );
  // Write strobe timing
  smcm_len_decode u_wrwe (
    .setup_i(setup_q[cs_q][5:0]),
    .pulse_i(pulse_q[cs_q][6:0]),
    .cycle_i(cycle_q[cs_q][8:0]),
    .timing_o(wr_we_t)
  );

  // Controlling strobe timing per direction
  wire use_strobe = wr_q ? wr_ctrl_strobe : rd_ctrl_strobe;
  wire [9:0] ctl_setup = wr_q ? (wr_ctrl_strobe ? wr_we_t.setup : wr_cs_t.setup)
                              : (rd_ctrl_strobe ? rd_rd_t.setup : rd_cs_t.setup);
  // In a page hit the read strobe pulse sets the later accesses
  wire [9:0] rd_pulse_sel = (page_mode_en && page_hit_q) ? rd_rd_t.pulse : rd_cs_t.pulse;
  wire [9:0] ctl_pulse_raw = wr_q ? (wr_ctrl_strobe ? wr_we_t.pulse : wr_cs_t.pulse)
                                  : (rd_ctrl_strobe && !page_mode_en ? rd_rd_t.pulse : rd_pulse_sel);
  // Zero pulse is promoted to one cycle
  wire [9:0] ctl_pulse = (ctl_pulse_raw == 10'h000) ? 10'h001 : ctl_pulse_raw;
  wire [9:0] cyc_len = wr_q ? wr_we_t.cycle : rd_rd_t.cycle;
  // Page hits zero the setup count; one setup cycle still passes
  wire [9:0] eff_setup = (!wr_q && page_mode_en && page_hit_q) ? 10'h000 : ctl_setup;

  // Wait handling, only sampled in the pulse phase
  // Limitation: the pin arrives two cycles late, so very short pulses never see it
  wire in_pulse = (state_q == SMCM_PULSE);
  wire frozen = in_pulse && (wait_mode == SMCM_WAIT_FROZEN) && !wait_sync;
  wire pulse_end = in_pulse && (cnt_q == ctl_pulse - 10'h001);
  wire ready_hold = pulse_end && (wait_mode == SMCM_WAIT_READY) && !wait_sync;
  wire stall = frozen || ready_hold;

  // Page offset mask: 4, 8, 16 or 32 bytes
  wire [ADDR_W-1:0] page_mask = ~((ADDR_W'(4) << page_size_sel) - ADDR_W'(1));
  // Hit needs the same select, a read, and the previous request's page
  wire hit_now = page_valid_q && !req_we_i && (req_cs_i == cs_q)
                 && ((req_adr_i & page_mask) == (page_adr_q & page_mask));

  // The optimisation belongs to the select that just read, not to the one asking
  wire flt_opt = mode_q[fcs_q][SMCM_F_TDFOPT];
  // Another select must wait out float plus turnaround
  wire float_busy = (flt_q != 5'h00) && (req_cs_i != fcs_q);
  // Same bar seen from inside an access that has already started
  wire float_bar_cur = (flt_q != 5'h00) && (cs_q != fcs_q);
  // Without optimisation floats fully precede another select's next access
  wire can_start = req_i && (state_q == SMCM_IDLE) && !(float_busy && !flt_opt);
  // With optimisation floats overlap setup, but pulse still waits
  wire setup_blocked = float_bar_cur && flt_opt && (state_q == SMCM_SETUP)
                       && (cnt_q + 10'h001 >= eff_setup);

  // Register write with byte lanes and masked reserved bits
  // Lanes merge with the old word before reserved bits are cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CS; i++) begin
        setup_q[i] <= SMCM_RST_SETUP;
        pulse_q[i] <= SMCM_RST_PULSE;
        cycle_q[i] <= SMCM_RST_CYCLE;
        mode_q[i] <= SMCM_RST_MODE;
      end
    end else if (wb_wr) begin
      case (reg_off)
        SMCM_OFF_SETUP: setup_q[reg_cs] <= ((setup_q[reg_cs] & ~byte_mask) | (dat_i & byte_mask)) & SMCM_SETUP_MASK;
        SMCM_OFF_PULSE: pulse_q[reg_cs] <= ((pulse_q[reg_cs] & ~byte_mask) | (dat_i & byte_mask)) & SMCM_PULSE_MASK;
        SMCM_OFF_CYCLE: cycle_q[reg_cs] <= ((cycle_q[reg_cs] & ~byte_mask) | (dat_i & byte_mask)) & SMCM_CYCLE_MASK;
        SMCM_OFF_MODE: mode_q[reg_cs] <= ((mode_q[reg_cs] & ~byte_mask) | (dat_i & byte_mask)) & SMCM_MODE_MASK;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped words read zero and still ack
  // Status is read-only and shows the bar as the current request sees it
  wire [31:0] status_word = {19'h00000, float_busy, flt_q, 1'b0, fcs_q, 3'(state_q)};
  wire [31:0] rd_word = reg_status ? status_word
                      : !reg_in_cs ? 32'h00000000
                      : (reg_off == SMCM_OFF_SETUP) ? setup_q[reg_cs]
                      : (reg_off == SMCM_OFF_PULSE) ? pulse_q[reg_cs]
                      : (reg_off == SMCM_OFF_CYCLE) ? cycle_q[reg_cs]
                      : (reg_off == SMCM_OFF_MODE) ? mode_q[reg_cs] : 32'h00000000;

  // One-cycle ack, dropped the cycle after
  // Read word is taken at the request edge, so it stands together with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      rdat_q <= wb_req ? rd_word : rdat_q;
    end
  end
  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // Access sequencer; cnt_q counts phase cycles, tot_q whole cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SMCM_IDLE;
      cnt_q <= 10'h000;
      tot_q <= 10'h000;
      cs_q <= 3'h0;
      wr_q <= 1'b0;
      be_q <= 4'h0;
      page_hit_q <= 1'b0;
    end else begin
      case (state_q)
        // Select and direction stay fixed for the whole cycle
        SMCM_IDLE: begin
          if (can_start) begin
            state_q <= SMCM_SETUP;
            cs_q <= req_cs_i;
            wr_q <= req_we_i;
            be_q <= req_be_i;
            page_hit_q <= hit_now;
            cnt_q <= 10'h000;
            tot_q <= 10'h000;
          end
        end
        // Setup may be held at its end by another select's float
        SMCM_SETUP: begin
          if (!setup_blocked) begin
            tot_q <= tot_q + 10'h001;
            if (cnt_q + 10'h001 >= eff_setup) begin
              state_q <= SMCM_PULSE;
              cnt_q <= 10'h000;
            end else begin
              cnt_q <= cnt_q + 10'h001;
            end
          end
        end
        // Frozen or ready wait holds both counters
        SMCM_PULSE: begin
          if (!stall) begin
            tot_q <= tot_q + 10'h001;
            if (pulse_end) begin
              state_q <= SMCM_HOLD;
              cnt_q <= 10'h000;
            end else begin
              cnt_q <= cnt_q + 10'h001;
            end
          end
        end
        SMCM_HOLD: begin
          // Hold lasts until the total programmed cycle is spent; keeps it at least one
          tot_q <= tot_q + 10'h001;
          if (tot_q + 10'h001 >= cyc_len) begin
            state_q <= SMCM_IDLE;
          end
        end
        default: state_q <= SMCM_IDLE;
      endcase
    end
  end

  // Combinational so the requester sees it in the last hold cycle
  wire access_end = (state_q == SMCM_HOLD) && (tot_q + 10'h001 >= cyc_len);
  assign req_done_o = access_end;

  // Float counter after reads: float_cycles plus a turnaround cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_q <= 5'h00;
      fcs_q <= 3'h0;
      page_valid_q <= 1'b0;
      page_adr_q <= '0;
    end else begin
      if (access_end && !wr_q) begin
        flt_q <= {1'b0, float_cycles} + 5'h01;
        fcs_q <= cs_q;
      end else if (flt_q != 5'h00) begin
        flt_q <= flt_q - 5'h01;
      end
      // Every accepted request opens a page; a write closes it
      if (can_start) begin
        page_adr_q <= req_adr_i;
        page_valid_q <= !req_we_i;
      end
    end
  end

  // Strobe generation; the controlling strobe spans pulse, select spans the cycle
  // Read and write strobes fall in the pulse phase, and with select control also in a zero-count setup
  wire active = (state_q != SMCM_IDLE);
  wire strobe_on = in_pulse || (state_q == SMCM_SETUP && !use_strobe && cnt_q >= eff_setup);
  wire wide_bus = (bus_width_sel != SMCM_DBW_8);
  wire bwr_mode = wide_bus && byte_write_type;
  smcm_strobes_t strobes_d;
  logic [NUM_CS-1:0] cs_n_q;
  always_comb begin
    strobes_d = '1;
    strobes_d.cs_n = !active;
    strobes_d.rd_n = !(active && !wr_q && strobe_on);
    if (wr_q && strobe_on) begin
      if (bwr_mode) begin
        strobes_d.bwr_n = ~be_q;
      end else begin
        strobes_d.we_n = 1'b0;
      end
    end
    if (active && !bwr_mode) begin
      strobes_d.bls_n = ~be_q;
    end
  end

  // Registered pin drive avoids glitches on strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobes_o <= '1;
      cs_n_q <= '1;
      mem_adr_o <= '0;
    end else begin
      strobes_o <= strobes_d;
      cs_n_q <= active ? ~(NUM_CS'(1) << cs_q) : '1;
      mem_adr_o <= can_start ? req_adr_i : mem_adr_o;
    end
  end
  assign cs_n_o = cs_n_q;
endmodule // smcm_ctrl

// ==== tb/smcm_ctrl_props.sv ====
`timescale 1ns/1ns
// Port-level checks on the register slave, access port and strobes
module smcm_ctrl_props import smcm_pkg::*; #(
  parameter int NUM_CS = 8,
  parameter int ADDR_W = 26
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic req_i,
  input wire logic req_done_o,
  input wire logic [NUM_CS-1:0] cs_n_o,
  input wire smcm_strobes_t strobes_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Slave answers exactly one cycle after taking a request
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("register ack late");
  chk_ack_single: assert property ($rose(ack_o) |=> $fell(ack_o))
    else $error("register ack too long");
  // Completion is a lone pulse; an idle cycle plus a new access must follow
  chk_done_gap: assert property (req_done_o |=> !req_done_o [*2])
    else $error("access completion too close");
  // Select still low in the last cycle of the access
  chk_done_held: assert property (req_done_o |-> !strobes_o.cs_n)
    else $error("select released before completion");
  // Never two selects low at once
  chk_select_one: assert property ($onehot0(~cs_n_o))
    else $error("two selects active");
  chk_rd_wr_apart: assert property (!strobes_o.rd_n |-> strobes_o.we_n && &strobes_o.bwr_n)
    else $error("read and write strobes overlap");
  chk_byte_split: assert property (!strobes_o.we_n |-> &strobes_o.bwr_n)
    else $error("write strobe with byte write strobes");
  chk_strobe_end: assert property (req_done_o |=> strobes_o.rd_n && strobes_o.we_n)
    else $error("strobe still low after access");
endmodule // smcm_ctrl_props

bind smcm_ctrl smcm_ctrl_props #(.NUM_CS(NUM_CS), .ADDR_W(ADDR_W)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .req_i(req_i), .req_done_o(req_done_o),
  .cs_n_o(cs_n_o), .strobes_o(strobes_o));

// ==== tb/smcm_mem_model.sv ====
`timescale 1ns/1ns
// Slow peripheral: holds its wait line low for a set count per pulse
module smcm_mem_model import smcm_pkg::*; (
  input wire logic clk_i,
  input wire smcm_strobes_t strobes_i,
  input wire logic [7:0] stall_i,
  output logic wait_n_o
);
  logic busy;
  logic [7:0] cnt_q = 8'h00;
  // Line is driven high whenever we are not stalling
  assign busy = !strobes_i.rd_n || !strobes_i.we_n || strobes_i.bwr_n != 4'hF;
  assign wait_n_o = !(busy && cnt_q < stall_i);
  // Cycles spent in the current strobe pulse
  always_ff @(posedge clk_i) begin
    cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
  end
endmodule // smcm_mem_model

// ==== tb/static_memory_cycle_mode_control_test.sv ====
`timescale 1ns/1ns
// Registers over the bus, then timed accesses against a slow peripheral
module static_memory_cycle_mode_control_test import smcm_pkg::*; ;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, req_i = 1'h0, req_we_i = 1'h0;
  logic ack_o, req_done_o, wait_n, we_seen;
  logic [7:0] adr_i = 8'h00, cs_n_o, stall = 8'h00;
  logic [3:0] sel_i = 4'hF, req_be_i = 4'h1, bwr_and, bls_and;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [2:0] req_cs_i = 3'h0;
  logic [25:0] req_adr_i = 26'h0;
  smcm_strobes_t strobes_o;
  int fails = 0, cmp_count = 0, tot, st, lo;

  always #4 clk_i = ~clk_i;

  smcm_ctrl dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .req_i,
    .req_we_i, .req_cs_i, .req_adr_i, .req_be_i, .req_done_o, .wait_input_i(wait_n), .cs_n_o, .strobes_o,
    .mem_adr_o());
  smcm_mem_model far (.clk_i, .strobes_i(strobes_o), .stall_i(stall), .wait_n_o(wait_n));

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'h1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // One classic bus cycle; held until ack, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'h1 && n++ < 40) @(posedge clk_i);
    chk(n < 40, "bus hang");
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic setcs(input logic [2:0] c, input logic [31:0] s, p, y, m);
    wb(1'h1, {1'h0, c, SMCM_OFF_SETUP}, s);
    wb(1'h1, {1'h0, c, SMCM_OFF_PULSE}, p);
    wb(1'h1, {1'h0, c, SMCM_OFF_CYCLE}, y);
    wb(1'h1, {1'h0, c, SMCM_OFF_MODE}, m);
  endtask

  // Access held until completion; counts length, strobe start and strobe low time
  task automatic acc(input logic w, input logic [2:0] c, input logic [25:0] a);
    tot = 0;
    st = 0;
    lo = 0;
    we_seen = 1'h0;
    bwr_and = 4'hF;
    bls_and = 4'hF;
    req_i <= 1'h1;
    req_we_i <= w;
    req_cs_i <= c;
    req_adr_i <= a;
    do begin
      @(posedge clk_i);
      tot++;
      if (!strobes_o.rd_n || !strobes_o.we_n || strobes_o.bwr_n != 4'hF) begin
        lo++;
        if (st == 0) st = tot;
      end
      if (!strobes_o.we_n) we_seen = 1'h1;
      bwr_and &= strobes_o.bwr_n;
      bls_and &= strobes_o.bls_n;
    end while (req_done_o !== 1'h1 && tot < 2000);
    chk(tot < 2000, "access hang");
    req_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic t_regs;
    wb(1'h0, 8'h00, 32'h0);
    chk(q === SMCM_RST_SETUP, "setup reset");
    wb(1'h0, 8'h74, 32'h0);
    chk(q === SMCM_RST_PULSE, "pulse reset");
    wb(1'h0, 8'h38, 32'h0);
    chk(q === SMCM_RST_CYCLE, "cycle reset");
    wb(1'h1, 8'h7C, 32'hFFFFFFFF);
    wb(1'h0, 8'h7C, 32'h0);
    chk(q === SMCM_MODE_MASK, "mode bits");
    wb(1'h0, 8'h6C, 32'h0);
    chk(q === SMCM_RST_MODE, "mode copy disturbed");
    wb(1'h1, 8'hF0, 32'hFFFFFFFF);
    wb(1'h0, 8'hF0, 32'h0);
    chk(q === 32'h0, "unmapped read");
    $display("regs done");
  endtask

  task automatic run(input logic w, input logic [31:0] s, p, y);
    setcs(3'h1, s, p, y, 32'h00002003);
    acc(w, 3'h1, 26'h0);
  endtask

  task automatic t_time;
    int a;
    for (int w = 0; w < 2; w++) begin
      run(w[0], 32'h02020202, 32'h03030303, 32'h000A000A);
      a = tot;
      chk(lo == 3, "pulse length");
      run(w[0], 32'h02020202, 32'h03030303, 32'h008A008A);
      chk(tot - a == 256, "cycle length");
    end
    run(1'h0, 32'h02020202, 32'h03030303, 32'h010A010A);
    a = st;
    run(1'h0, 32'h22222222, 32'h03030303, 32'h010A010A);
    chk(st - a == 128, "setup length");
    run(1'h0, 32'h02020202, 32'h41414141, 32'h010A010A);
    chk(lo == 257, "long pulse");
    $display("timing done");
  endtask

  task automatic t_wait;
    int b;
    // Pulse long enough for the wait pin to pass its synchroniser in time
    setcs(3'h2, 32'h01010101, 32'h08080808, 32'h000C000C, 32'h00002003);
    acc(1'h0, 3'h2, 26'h0);
    b = tot;
    stall <= 8'h08;
    // Reserved code must behave as disabled
    for (int m = 0; m < 4; m++) begin
      wb(1'h1, 8'h2C, 32'h00002003 | 32'(m << 4));
      acc(1'h0, 3'h2, 26'h0);
      if (m < 2) chk(tot == b, "wait not ignored");
      else chk(tot > b && tot <= b + 12, "wait stretch");
    end
    stall <= 8'h00;
    $display("wait done");
  endtask

  task automatic byte_access_type(input logic [1:0] dw, input logic ba, w, x, input logic [3:0] eb, ec);
    wb(1'h1, 8'h3C, {18'h0, dw, 3'h0, ba, 8'h03});
    acc(w, 3'h3, 26'h0);
    chk(we_seen === x && bwr_and === eb && (dw == 2'h0 || bls_and === ec), "byte strobes");
  endtask

  task automatic t_bat;
    setcs(3'h3, 32'h01010101, 32'h03030303, 32'h000A000A, 32'h00002003);
    byte_access_type(2'h2, 1'h1, 1'h1, 1'h0, 4'hE, 4'hF);
    byte_access_type(2'h2, 1'h1, 1'h0, 1'h0, 4'hF, 4'hF);
    byte_access_type(2'h2, 1'h0, 1'h1, 1'h1, 4'hF, 4'hE);
    byte_access_type(2'h2, 1'h0, 1'h0, 1'h0, 4'hF, 4'hE);
    byte_access_type(2'h1, 1'h1, 1'h1, 1'h0, 4'hE, 4'hF);
    byte_access_type(2'h0, 1'h1, 1'h1, 1'h1, 4'hF, 4'hF);
    $display("byte access done");
  endtask

  // Read on one select, then straight away on another; returns second length
  task automatic pair(input logic [31:0] m, output int d);
    wb(1'h1, 8'h5C, m);
    acc(1'h0, 3'h5, 26'h0);
    acc(1'h0, 3'h6, 26'h0);
    d = tot;
  endtask

  task automatic t_float;
    int d0, d1, dz;
    setcs(3'h6, 32'h03030303, 32'h03030303, 32'h000A000A, 32'h00002003);
    setcs(3'h5, 32'h01010101, 32'h03030303, 32'h000A000A, 32'h000F2003);
    acc(1'h0, 3'h5, 26'h0);
    // Another select now asks, so it must see the float bar
    req_cs_i <= 3'h6;
    wb(1'h0, SMCM_OFF_STATUS, 32'h0);
    chk(q[12] === 1'h1 && q[11:7] !== 5'h00, "float busy");
    pair(32'h000F2003, d0);
    pair(32'h001F2003, d1);
    pair(32'h00002003, dz);
    chk(d0 > dz, "float bar");
    chk(d1 < d0, "float overlap");
    chk(d1 > dz, "float bar kept with overlap");
    $display("float done");
  endtask

  task automatic pg(input logic pm, input logic [1:0] ps, input logic [25:0] a1, a2, input logic hit);
    int t1;
    wb(1'h1, 8'h4C, {2'h0, ps, 3'h0, pm, 8'h00, 8'h20, 8'h03});
    acc(1'h0, 3'h4, a1);
    t1 = tot;
    acc(1'h0, 3'h4, a2);
    chk(hit ? tot < t1 : tot == t1, "page timing");
  endtask

  task automatic t_page;
    setcs(3'h4, 32'h01010101, 32'h06020303, 32'h00010001, 32'h00002003);
    pg(1'h1, 2'h0, 26'h0, 26'h1, 1'h1);
    pg(1'h1, 2'h0, 26'h8, 26'hC, 1'h0);
    pg(1'h1, 2'h1, 26'h10, 26'h14, 1'h1);
    pg(1'h1, 2'h2, 26'h20, 26'h2C, 1'h1);
    pg(1'h1, 2'h3, 26'h40, 26'h5C, 1'h1);
    pg(1'h0, 2'h3, 26'h40, 26'h44, 1'h0);
    $display("page done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs;
    t_time;
    t_wait;
    t_bat;
    t_float;
    t_page;
    test_done;
  end

  // Tests need under 8000 cycles; 50000 leaves a wide margin
  initial begin
    #400000;
    fails++;
    test_done;
  end
endmodule // static_memory_cycle_mode_control_test
